// [src/hcm_heater_cycle_modulator.v]
// Zero-cross synchronised cycle modulator for one heater switch.
// Assumes zero_cross_in pulses once per power cycle; samples arrive per
// window from an external converter; currents are in 0.1 A units.
`include "hcm_defines.vh"
module hcm_heater_cycle_modulator #(
   parameter TENTH_SECOND_CYCLES = `HCM_TENTH_S_CYC
) (
   // Clock and reset.
   input  wire        clk_in,
   input  wire        reset_n_in,
   // Register port.
   input  wire [3:0]  reg_addr_in,
   input  wire [15:0] reg_wdata_in,
   input  wire        reg_wr_in,
   input  wire        reg_rd_in,
   output reg  [15:0] reg_rdata_out,
   // Mains and heater side.
   input  wire        zero_cross_in,
   input  wire        heat_call_in,
   input  wire [9:0]  current_sample_in,
   output reg         heater_on_out,
   output reg         sample_strobe_out,
   output reg  [9:0]  current_sample_out,
   output reg         window_done_out
);
   localparam [26:0] TENTH_LAST = TENTH_SECOND_CYCLES - 1;

   // Register state.
   reg  [2:0]  ctrl_q;
   reg  [8:0]  limit_q;
   reg  [9:0]  ss_period_q;
   reg  [3:0]  prop_duty_q;
   reg  [8:0]  full_cur_q;

   // Frame and duty state.
   reg  [3:0]  cycle_q;
   reg  [3:0]  duty_q;
   reg  [3:0]  duty_d;

   // Power-limit loop state.
   reg  [3:0]  limit_duty_q;
   reg  [1:0]  settle_q;

   // Soft-start state.
   reg  [3:0]  ss_duty_q;
   reg         ss_active_q;
   reg  [13:0] ss_tick_q;
   reg  [26:0] tenth_q;
   reg  [3:0]  ss_top_q;

   // Measurement window state.
   reg  [8:0]  sample_cnt_q;
   reg  [18:0] cur_sum_q;
   reg  [8:0]  avg_cur_q;
   reg         win_q;

   // Combinational helpers.
   wire        limit_en;
   wire        ss_en;
   wire        frame_end;
   wire        tenth_tick;
   wire [9:0]  pat_bits;
   wire        pat_on;
   wire [12:0] lim_x10;
   wire [12:0] lim_ratio;
   wire [3:0]  est_duty;
   wire [3:0]  ss_top_nz;
   wire [13:0] ss_x10;
   wire [13:0] ss_hold;
   wire [13:0] est_cur_x10;
   wire [13:0] est_cur;
   wire [18:0] win_sum;
   wire [18:0] win_avg;

   assign limit_en   = ctrl_q[`HCM_CTRL_LIMIT_EN] & (limit_q != 9'h000);
   assign ss_en      = ctrl_q[`HCM_CTRL_SS_EN] & (ss_period_q != 10'h000);
   assign frame_end  = zero_cross_in &
                       (cycle_q == (`HCM_FRAME_CYCLES - 4'h1));
   assign tenth_tick = (tenth_q == TENTH_LAST);

   // Even spread: cycle c is on when floor((c+1)d/10) > floor(cd/10).
   genvar c;
   generate
      for (c = 0; c < 10; c = c + 1) begin : g_pat
         localparam [7:0] HI_MUL = c + 1;
         localparam [7:0] LO_MUL = c;
         wire [7:0] hi_prod;
         wire [7:0] lo_prod;
         assign hi_prod = HI_MUL * {4'h0, duty_q};
         assign lo_prod = LO_MUL * {4'h0, duty_q};
         assign pat_bits[c] = ((hi_prod / 8'h0a) > (lo_prod / 8'h0a));
      end
   endgenerate
   assign pat_on = pat_bits[cycle_q];

   // Estimated top duty from full current and limit.
   assign lim_x10   = {4'h0, limit_q} * 13'h000a;
   assign lim_ratio = (full_cur_q == 9'h000) ? 13'h1fff :
                      lim_x10 / {4'h0, full_cur_q};
   assign est_duty  = (!limit_en || lim_ratio > 13'h000a) ? `HCM_DUTY_MAX :
                      lim_ratio[3:0];

   // Step hold in tenth-seconds: period over top duty.
   assign ss_top_nz = (ss_top_q == 4'h0) ? 4'h1 : ss_top_q;
   assign ss_x10    = {4'h0, ss_period_q} * 14'h000a;
   assign ss_hold   = ss_x10 / {10'h000, ss_top_nz};

   // Average current estimate: full current times duty fraction.
   assign est_cur_x10 = {5'h00, full_cur_q} * {10'h000, duty_q};
   assign est_cur     = est_cur_x10 / 14'h000a;

   // Window sum and mean including the current sample.
   assign win_sum = cur_sum_q + {9'h000, current_sample_in};
   assign win_avg = win_sum / {10'h000, `HCM_SAMPLES};

   // Duty selection: caps from limit, ramp and proportional demand.
   always @* begin
      duty_d = limit_en ? limit_duty_q : `HCM_DUTY_MAX;
      if (ss_active_q && ss_duty_q < duty_d)
         duty_d = ss_duty_q;
      if (ctrl_q[`HCM_CTRL_PROP_EN] && prop_duty_q < duty_d)
         duty_d = prop_duty_q;
      if (!heat_call_in)
         duty_d = 4'h0;
   end

   // Register writes; out-of-range nonzero limit and soft-start period writes are ignored, proportional duty is clamped to ten.
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         ctrl_q <= 3'h4;
         limit_q <= 9'h000;
         ss_period_q <= 10'h000;
         prop_duty_q <= `HCM_DUTY_MAX;
         full_cur_q <= 9'h000;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            `HCM_ADDR_CTRL: ctrl_q <= reg_wdata_in[2:0];
            `HCM_ADDR_LIMIT:
               if (reg_wdata_in[8:0] <= `HCM_LIMIT_MAX)
                  limit_q <= reg_wdata_in[8:0];
            `HCM_ADDR_SSPERIOD:
               if (reg_wdata_in[9:0] == 10'h000 ||
                   (reg_wdata_in[9:0] >= `HCM_SS_MIN &&
                    reg_wdata_in[9:0] <= `HCM_SS_MAX))
                  ss_period_q <= reg_wdata_in[9:0];
            `HCM_ADDR_PROPDUTY:
               prop_duty_q <= (reg_wdata_in[3:0] > `HCM_DUTY_MAX) ?
                              `HCM_DUTY_MAX : reg_wdata_in[3:0];
            `HCM_ADDR_FULLCUR: full_cur_q <= reg_wdata_in[8:0];
            default: ;
         endcase
      end
   end

   // Register reads: data stand one cycle, zero otherwise.
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         reg_rdata_out <= 16'h0000;
      end else begin
         reg_rdata_out <= 16'h0000;
         if (reg_rd_in) begin
            case (reg_addr_in)
               `HCM_ADDR_CTRL:     reg_rdata_out <= {13'h0, ctrl_q};
               `HCM_ADDR_LIMIT:    reg_rdata_out <= {7'h0, limit_q};
               `HCM_ADDR_SSPERIOD: reg_rdata_out <= {6'h0, ss_period_q};
               `HCM_ADDR_PROPDUTY: reg_rdata_out <= {12'h0, prop_duty_q};
               `HCM_ADDR_STATUS:
                  reg_rdata_out <= {2'h0, ss_active_q, heater_on_out,
                                    ss_duty_q, limit_duty_q, duty_q};
               `HCM_ADDR_AVGCUR:   reg_rdata_out <= {7'h0, avg_cur_q};
               `HCM_ADDR_FULLCUR:  reg_rdata_out <= {7'h0, full_cur_q};
               default:            reg_rdata_out <= 16'h0000;
            endcase
         end
      end
   end

   // Frame counter and heater switch; changes only on a zero crossing.
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         cycle_q <= 4'h0;
         heater_on_out <= 1'b0;
         duty_q <= 4'h0;
      end else begin
         if (zero_cross_in) begin
            cycle_q <= frame_end ? 4'h0 : cycle_q + 4'h1;
            heater_on_out <= pat_on;
         end
         if (frame_end)
            duty_q <= duty_d;
      end
   end

   // Sampling: 300 per window, each a 10-bit result.
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         win_q <= 1'b0;
         sample_cnt_q <= 9'h000;
         cur_sum_q <= 19'h00000;
         avg_cur_q <= 9'h000;
         sample_strobe_out <= 1'b0;
         current_sample_out <= 10'h000;
         window_done_out <= 1'b0;
      end else begin
         window_done_out <= 1'b0;
         sample_strobe_out <= 1'b0;
         if (win_q) begin
            sample_strobe_out <= 1'b1;
            current_sample_out <= current_sample_in;
            cur_sum_q <= win_sum;
            if (sample_cnt_q == `HCM_SAMPLE_LAST) begin
               sample_cnt_q <= 9'h000;
               win_q <= 1'b0;
               window_done_out <= 1'b1;
               avg_cur_q <= win_avg[8:0];
               cur_sum_q <= 19'h00000;
            end else begin
               sample_cnt_q <= sample_cnt_q + 9'h001;
            end
         end
         // A frame end opens the next window, overriding its close.
         if (frame_end)
            win_q <= 1'b1;
      end
   end

   // Limit loop: steps only after settled windows.
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         limit_duty_q <= 4'h0;
         settle_q <= 2'h0;
      end else if (!heat_call_in || !limit_en) begin
         limit_duty_q <= 4'h0;
         settle_q <= 2'h0;
      end else if (window_done_out) begin
         if (settle_q < `HCM_SETTLE_WINDOWS) begin
            settle_q <= settle_q + 2'h1;
         end else begin
            settle_q <= 2'h0;
            if (est_cur > {5'h00, limit_q} && limit_duty_q != 4'h0)
               limit_duty_q <= limit_duty_q - 4'h1;
            else if (avg_cur_q < limit_q && limit_duty_q < `HCM_DUTY_MAX)
               limit_duty_q <= limit_duty_q + 4'h1;
         end
      end
   end

   // Tenth-second enable divider, running only during the ramp.
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         tenth_q <= 27'h0000000;
      end else if (!ss_active_q || tenth_tick) begin
         tenth_q <= 27'h0000000;
      end else begin
         tenth_q <= tenth_q + 27'h0000001;
      end
   end

   // Soft-start ramp: step hold counted in tenth-seconds.
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         ss_duty_q <= 4'h1;
         ss_active_q <= 1'b1;
         ss_tick_q <= 14'h0000;
         ss_top_q <= `HCM_DUTY_MAX;
      end else begin
         if (ss_active_q) begin
            if (!ss_en || ss_duty_q >= ss_top_q) begin
               ss_active_q <= 1'b0;
            end else if (tenth_tick) begin
               if (ss_tick_q + 14'h0001 >= ss_hold) begin
                  ss_tick_q <= 14'h0000;
                  ss_duty_q <= ss_duty_q + 4'h1;
               end else begin
                  ss_tick_q <= ss_tick_q + 14'h0001;
               end
            end
         end
         if (ss_active_q && ss_duty_q == 4'h1 && ss_tick_q == 14'h0000)
            ss_top_q <= est_duty;
      end
   end
endmodule // hcm_heater_cycle_modulator

// [pkg/hcm_defines.vh]
// Constants for the heater cycle modulator: register map, fields, timing.
// Assumes a 100 MHz clock and one zero-cross pulse per mains power cycle.
`ifndef HCM_DEFINES_VH
`define HCM_DEFINES_VH
`define HCM_ADDR_CTRL      4'h0
`define HCM_ADDR_LIMIT     4'h1
`define HCM_ADDR_SSPERIOD  4'h2
`define HCM_ADDR_PROPDUTY  4'h3
`define HCM_ADDR_STATUS    4'h4
`define HCM_ADDR_AVGCUR    4'h5
`define HCM_ADDR_FULLCUR   4'h6
`define HCM_CTRL_LIMIT_EN  0
`define HCM_CTRL_PROP_EN   1
`define HCM_CTRL_SS_EN     2
`define HCM_FRAME_CYCLES   4'ha
`define HCM_DUTY_MAX       4'ha
`define HCM_SAMPLES        9'h12c
`define HCM_SAMPLE_LAST    9'h12b
`define HCM_LIMIT_MIN      9'h001
`define HCM_LIMIT_MAX      9'h12c
`define HCM_SS_MIN         10'h00a
`define HCM_SS_MAX         10'h3e7
`define HCM_SETTLE_WINDOWS 2'h2
`define HCM_CLK_HZ         100000000
`define HCM_TENTH_S_CYC    (`HCM_CLK_HZ / 10)
`endif

// [verification/hcm_checker_assertions.sv]
// Port checker for the heater cycle modulator, bound to its top module.
// Assumes one zero-cross pulse per power cycle from the mains side.
module hcm_checker (
   // Clock and reset.
   input wire logic        clk_in,
   input wire logic        reset_n_in,
   // Register port.
   input wire logic [3:0]  reg_addr_in,
   input wire logic        reg_rd_in,
   input wire logic [15:0] reg_rdata_out,
   // Mains side.
   input wire logic        zero_cross_in,
   input wire logic [9:0]  current_sample_in,
   input wire logic        heater_on_out,
   input wire logic        sample_strobe_out,
   input wire logic [9:0]  current_sample_out,
   input wire logic        window_done_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] run_q;
   always_ff @(posedge clk_in) begin
      if (!reset_n_in || !sample_strobe_out || window_done_out)
         run_q <= 9'h000;
      else run_q <= run_q + 9'h001;
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   sequence rd_unmapped;
      reg_rd_in && (reg_addr_in > 4'h6);
   endsequence
   sequence rd_status;
      reg_rd_in && (reg_addr_in == 4'h4);
   endsequence
   a_heater_at_zc:
      assert property ($changed(heater_on_out) |-> $past(zero_cross_in))
      else $error("heater switched away from a zero crossing");
   a_read_data_slot:
      assert property (reg_rdata_out != 16'h0000 |-> $past(reg_rd_in))
      else $error("read data outside its slot");
   a_unmapped_zero:
      assert property (rd_unmapped |=> reg_rdata_out == 16'h0000)
      else $error("unmapped read not zero");
   a_status_duty:
      assert property (rd_status |=> reg_rdata_out[3:0] <= 4'ha
                       && reg_rdata_out[7:4] <= 4'ha)
      else $error("duty field above ten");
   a_sample_copy:
      assert property (sample_strobe_out |->
                       current_sample_out == $past(current_sample_in))
      else $error("sample copy wrong");
   a_window_length:
      assert property (window_done_out |-> run_q == 9'h12b)
      else $error("window end not at sample 300");
   a_strobe_bounded:
      assert property (sample_strobe_out |-> run_q < 9'h12c)
      else $error("window longer than 300 samples");
   a_done_on_strobe:
      assert property (window_done_out |-> sample_strobe_out)
      else $error("window end without a sample");
endmodule // hcm_checker

bind hcm_heater_cycle_modulator hcm_checker chk_u (
   .clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
   .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
   .zero_cross_in(zero_cross_in), .current_sample_in(current_sample_in),
   .heater_on_out(heater_on_out), .sample_strobe_out(sample_strobe_out),
   .current_sample_out(current_sample_out),
   .window_done_out(window_done_out));

// [verification/hcm_mains_model.sv]
// Mains zero-cross detector and heater switch with a resistive load.
// Assumes the system clock; one power cycle is PERIOD clocks.
module hcm_mains_model #(
   parameter int PERIOD = 30
) (
   input  wire logic       clk_in,
   input  wire logic       reset_n_in,
   input  wire logic       heater_on_in,
   input  wire logic [9:0] full_cur_in,
   output logic            zero_cross_out,
   output logic [9:0]      current_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int ph_q;
   always_ff @(posedge clk_in) begin
      zero_cross_out <= reset_n_in && ph_q == PERIOD - 1;
      if (!reset_n_in || ph_q == PERIOD - 1) ph_q <= 0;
      else ph_q <= ph_q + 1;
   end
   // The load draws full current only while the switch is closed.
   assign current_out = heater_on_in ? full_cur_in : 10'h000;
endmodule // hcm_mains_model

// [verification/tb_top.sv]
// Self-checking bench for the heater cycle modulator.
// Assumes the mains model gives 30 clocks per power cycle.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 0, reset_n_in = 0, wr = 0, rd = 0, zc, heat = 0, hon;
   logic [3:0] ad = 4'h0;
   logic [15:0] wd = 16'h0000, rdat, s;
   logic [9:0] cur;
   logic [9:0] p1, p2;
   int failures = 0, n_compared = 0;
   hcm_heater_cycle_modulator #(.TENTH_SECOND_CYCLES(10)) dut_u (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(ad),
      .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdat), .zero_cross_in(zc), .heat_call_in(heat),
      .current_sample_in(cur), .heater_on_out(hon),
      .sample_strobe_out(), .current_sample_out(), .window_done_out());
   hcm_mains_model mains_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .heater_on_in(hon), .full_cur_in(10'h064), .zero_cross_out(zc),
      .current_out(cur));
   initial forever #5 clk_in = ~clk_in;
   task print_verdict();
      if (failures == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task wrr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_in) begin wr <= 1; ad <= a; wd <= d; end
      @(posedge clk_in) wr <= 0;
   endtask
   task rdd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_in) begin rd <= 1; ad <= a; end
      @(posedge clk_in) rd <= 0;
      #1 d = rdat;
   endtask
   task zcw(input int n);
      int i;
      repeat (n) begin
         i = 0;
         do begin @(posedge clk_in); i++; end while (zc !== 1'b1 && i < 99);
         if (i >= 99) begin failures++; print_verdict(); end
      end
   endtask
   task grab(output logic [9:0] p);
      for (int k = 0; k < 10; k++) begin zcw(1); #1 p[k] = hon; end
   endtask
   task t_regs();
      rdd(4'h0, s); chk("ctrl", 16'h0004, s);
      wrr(4'h1, 16'h012c); wrr(4'h1, 16'h012d);
      rdd(4'h1, s); chk("limit", 16'h012c, s);
      wrr(4'h2, 16'h000a); wrr(4'h2, 16'h0009);
      rdd(4'h2, s); chk("ss_period", 16'h000a, s);
      rdd(4'h7, s); chk("unmapped", 16'h0000, s);
   endtask
   task t_no_heat();
      zcw(20); grab(p1); chk("idle_pattern", 16'h0000, {6'h0, p1});
      rdd(4'h4, s); chk("idle_duty", 16'h0000, {12'h0, s[3:0]});
   endtask
   task t_duty();
      wrr(4'h0, 16'h0002);
      for (int d = 0; d <= 10; d++) begin
         wrr(4'h3, d[15:0]); zcw(25); grab(p1); grab(p2);
         chk("on_count", d[15:0], 16'($countones(p1)));
         chk("pattern", {6'h0, p1}, {6'h0, p2});
      end
   endtask
   task t_limit();
      wrr(4'h6, 16'h0064); wrr(4'h1, 16'h0037); wrr(4'h0, 16'h0001);
      zcw(250);
      rdd(4'h4, s);
      chk("limit_duty", 16'h0001, 16'(s[7:4] inside {4'h5, 4'h6}));
      grab(p1); chk("limited_on", 16'h0001, 16'($countones(p1) <= 6));
   endtask
   initial begin
      repeat (4) @(posedge clk_in);
      reset_n_in <= 1;
      t_regs();
      t_no_heat();
      @(posedge clk_in) heat <= 1;
      t_duty();
      t_limit();
      print_verdict();
   end
endmodule // tb_top
